// *** core/bit_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module bit_sync
  #(parameter int W = 8)
  (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
  );

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  // Two flops; only the second stage is read outside.
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
    end
  end

  assign o_sync = stage2_reg;

endmodule
`default_nettype wire

// *** core/event_irq.sv ***
`timescale 1ns/10ps
`default_nettype none
module event_irq
  #(parameter int W = 8)
  (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_event,
  input wire logic i_clear_wr,
  input wire logic i_enable_wr,
  input wire logic [W-1:0] i_wdata,
  output logic [W-1:0] o_status,
  output logic [W-1:0] o_enable,
  output logic o_irq
  );

  logic [W-1:0] status_reg;
  logic [W-1:0] status_next;
  logic [W-1:0] enable_reg;
  logic [W-1:0] enable_next;

  // A new event beats a clear written in the same cycle.
  always_comb
  begin
    status_next = status_reg;
    enable_next = enable_reg;
    if (i_clear_wr)
    begin
      status_next = status_next & ~i_wdata;
    end
    status_next = status_next | i_event;
    if (i_enable_wr)
    begin
      enable_next = i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      status_reg <= '0;
      enable_reg <= '0;
    end
    else
    begin
      status_reg <= status_next;
      enable_reg <= enable_next;
    end
  end

  assign o_status = status_reg;
  assign o_enable = enable_reg;
  assign o_irq = |(status_reg & enable_reg);

endmodule
`default_nettype wire

// *** core/gpio_summary_top.sv ***
// Contract
// RULE1 - Pin 8 field bits 15:14, input/low/high
// RULE2 - Pin 8 field ignored when pin mode 01
// RULE3 - Pin 7 field bits 13:12, input/low/high
// RULE4 - Pin 6 field 11:10, needs interface mode 0
// RULE5 - Pin 5 field bits 9:8, input/low/high
// RULE6 - Pin 4 field 7:6, needs 8k input 0
// RULE7 - Pin 3 field bits 5:4, input/low/high
// RULE8 - Pin 2 field 3:2, needs 8k output 0
// RULE9 - Pin 2 code 01 drives port B status
// RULE10 - Pin 1 field bits 1:0, input/low/high
// RULE11 - Pin 1 code 01 drives port A status
// RULE12 - Bit 4 set when any port interrupt
// RULE13 - Port summary and enable pull interrupt low
// RULE14 - Bit 0 set when enabled latched status
// RULE15 - Global summary and enable pull interrupt low
// RULE16 - All select fields reset to input
// RULE17 - Summaries read-only; interrupt releases when clear
`timescale 1ns/10ps
`default_nettype none
module gpio_summary_top
  import gpio_summary_pkg::*;
  #(parameter int PORT_INTERRUPT_STATUS_REG_W = 16,
    parameter int LATCHED_W = 16)
  (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic [NUM_PINS-1:0] i_pin_in,
  output logic [NUM_PINS-1:0] o_pin_out,
  output logic [NUM_PINS-1:0] o_pin_oe,
  input wire logic [ALT_PINS-1:0] i_alt_out,
  input wire logic [ALT_PINS-1:0] i_alt_oe,
  input wire logic [STATUS_BITS-1:0] i_port_a_status,
  input wire logic [STATUS_BITS-1:0] i_port_b_status,
  input wire logic [PORT_INTERRUPT_STATUS_REG_W-1:0] i_port_int_status,
  input wire logic [LATCHED_W-1:0] i_latched_status,
  input wire logic [LATCHED_W-1:0] i_latched_enable,
  output logic o_int_n,
  output logic o_event_irq
  );

  logic [DATA_W-1:0] pin_ctrl_reg;
  logic [DATA_W-1:0] pin_ctrl_next;
  global_cfg_t cfg_reg;
  global_cfg_t cfg_next;
  logic [SRC_W-1:0] src_a_reg;
  logic [SRC_W-1:0] src_a_next;
  logic [SRC_W-1:0] src_b_reg;
  logic [SRC_W-1:0] src_b_next;
  logic port_en_reg;
  logic port_en_next;
  logic glob_en_reg;
  logic glob_en_next;

  logic port_sum_reg;
  logic port_sum_next;
  logic glob_sum_reg;
  logic glob_sum_next;
  logic int_n_reg;
  logic int_n_next;

  pin_drive_t drive_reg;
  pin_drive_t drive_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [NUM_PINS-1:0] level_prev_reg;
  localparam int WARM_CYCLES = 3;
  logic [WARM_CYCLES-1:0] warm_reg;
  logic [WARM_CYCLES-1:0] warm_next;

  logic [NUM_PINS-1:0] pin_level;
  logic [NUM_PINS-1:0] pin_change;
  logic [NUM_PINS-1:0] evt_status;
  logic [NUM_PINS-1:0] evt_enable;
  logic wr_evt_clear;
  logic wr_evt_enable;
  logic [DATA_W-1:0] isr_value;
  logic [DATA_W-1:0] isr_en_value;
  logic [DATA_W-1:0] cfg_value;
  logic [DATA_W-1:0] src_value;
  logic status_a;
  logic status_b;

  bit_sync #(.W(NUM_PINS)) u_pin_sync
  (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_async(i_pin_in),
    .o_sync(pin_level)
  );

  // Pin level changes are the events that can raise the event interrupt.
  // Detection waits until the synchroniser and the previous level hold real pin levels.
  // This keeps a pin that idles high from raising a false event after reset.
  always_comb
  begin
    warm_next = {warm_reg[WARM_CYCLES-2:0], 1'b1};
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      level_prev_reg <= '0;
      warm_reg <= '0;
    end
    else
    begin
      level_prev_reg <= pin_level;
      warm_reg <= warm_next;
    end
  end

  assign pin_change = warm_reg[WARM_CYCLES-1] ? (pin_level ^ level_prev_reg) : '0;
  assign wr_evt_clear = i_wr && (i_addr == OFS_EVT_CLEAR);
  assign wr_evt_enable = i_wr && (i_addr == OFS_EVT_ENABLE);

  event_irq #(.W(NUM_PINS)) u_event_irq
  (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_event(pin_change),
    .i_clear_wr(wr_evt_clear),
    .i_enable_wr(wr_evt_enable),
    .i_wdata(i_wdata[NUM_PINS-1:0]),
    .o_status(evt_status),
    .o_enable(evt_enable),
    .o_irq(o_event_irq)
  );

  // Register writes.
  always_comb
  begin
    pin_ctrl_next = pin_ctrl_reg;
    cfg_next = cfg_reg;
    src_a_next = src_a_reg;
    src_b_next = src_b_reg;
    port_en_next = port_en_reg;
    glob_en_next = glob_en_reg;
    if (i_wr)
    begin
      case (i_addr)
        OFS_PIN_CTRL:
        begin
          pin_ctrl_next = i_wdata;
        end
        OFS_INT_SUMMARY_EN:
        begin
          port_en_next = i_wdata[PORT_INT_BIT];
          glob_en_next = i_wdata[GLOBAL_STATUS_BIT];
        end
        OFS_GLOBAL_CFG:
        begin
          cfg_next.pin_mode = i_wdata[CFG_PIN_MODE_LSB+:2];
          cfg_next.if_mode = i_wdata[CFG_IF_MODE_BIT];
          cfg_next.ref_in = i_wdata[CFG_REF_IN_BIT];
          cfg_next.ref_out = i_wdata[CFG_REF_OUT_BIT];
        end
        OFS_PORT_SRC:
        begin
          src_a_next = i_wdata[SRC_A_LSB+:SRC_W];
          src_b_next = i_wdata[SRC_B_LSB+:SRC_W];
        end
        default:
        begin
          pin_ctrl_next = pin_ctrl_reg;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pin_ctrl_reg <= PIN_CTRL_RST; // [RULE16]
      cfg_reg <= '0;
      src_a_reg <= '0;
      src_b_reg <= '0;
      port_en_reg <= 1'b0;
      glob_en_reg <= 1'b0;
    end
    else
    begin
      pin_ctrl_reg <= pin_ctrl_next;
      cfg_reg <= cfg_next;
      src_a_reg <= src_a_next;
      src_b_reg <= src_b_next;
      port_en_reg <= port_en_next;
      glob_en_reg <= glob_en_next;
    end
  end

  // Interrupt summary and the shared active-low interrupt pin.
  always_comb
  begin
    port_sum_next = |i_port_int_status; // [RULE12] [RULE17]
    glob_sum_next = |(i_latched_status & i_latched_enable); // [RULE14] [RULE17]
    int_n_next = 1'b1;
    if (port_sum_next && port_en_reg)
    begin
      int_n_next = 1'b0; // [RULE13]
    end
    if (glob_sum_next && glob_en_reg)
    begin
      int_n_next = 1'b0; // [RULE15]
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      port_sum_reg <= 1'b0;
      glob_sum_reg <= 1'b0;
      int_n_reg <= 1'b1;
    end
    else
    begin
      port_sum_reg <= port_sum_next;
      glob_sum_reg <= glob_sum_next;
      int_n_reg <= int_n_next; // [RULE17]
    end
  end

  // Pin drive, with global functions taking over pins 8, 6, 4 and 2.
  assign status_a = i_port_a_status[src_a_reg]; // [RULE11]
  assign status_b = i_port_b_status[src_b_reg]; // [RULE9]

  always_comb
  begin
    drive_next = '0;
    {drive_next.oe[0], drive_next.out[0]} =
      decode_sel(pin_field(pin_ctrl_reg, PIN1_LSB), 1'b1, status_a); // [RULE10] [RULE11]
    if (cfg_reg.ref_out)
    begin
      drive_next.oe[1] = i_alt_oe[0];
      drive_next.out[1] = i_alt_out[0];
    end
    else
    begin
      {drive_next.oe[1], drive_next.out[1]} =
        decode_sel(pin_field(pin_ctrl_reg, PIN2_LSB), 1'b1, status_b); // [RULE8] [RULE9]
    end
    {drive_next.oe[2], drive_next.out[2]} =
      decode_sel(pin_field(pin_ctrl_reg, PIN3_LSB), 1'b0, 1'b0); // [RULE7]
    if (cfg_reg.ref_in)
    begin
      drive_next.oe[3] = i_alt_oe[1];
      drive_next.out[3] = i_alt_out[1];
    end
    else
    begin
      {drive_next.oe[3], drive_next.out[3]} =
        decode_sel(pin_field(pin_ctrl_reg, PIN4_LSB), 1'b0, 1'b0); // [RULE6]
    end
    {drive_next.oe[4], drive_next.out[4]} =
      decode_sel(pin_field(pin_ctrl_reg, PIN5_LSB), 1'b0, 1'b0); // [RULE5]
    if (cfg_reg.if_mode)
    begin
      drive_next.oe[5] = i_alt_oe[2];
      drive_next.out[5] = i_alt_out[2];
    end
    else
    begin
      {drive_next.oe[5], drive_next.out[5]} =
        decode_sel(pin_field(pin_ctrl_reg, PIN6_LSB), 1'b0, 1'b0); // [RULE4]
    end
    {drive_next.oe[6], drive_next.out[6]} =
      decode_sel(pin_field(pin_ctrl_reg, PIN7_LSB), 1'b0, 1'b0); // [RULE3]
    if (cfg_reg.pin_mode == PIN_MODE_OVERRIDE)
    begin
      drive_next.oe[7] = i_alt_oe[3]; // [RULE2]
      drive_next.out[7] = i_alt_out[3];
    end
    else
    begin
      {drive_next.oe[7], drive_next.out[7]} =
        decode_sel(pin_field(pin_ctrl_reg, PIN8_LSB), 1'b0, 1'b0); // [RULE1] [RULE2]
    end
  end

  // Read-back values.
  always_comb
  begin
    isr_value = DATA_ZERO;
    isr_value[PORT_INT_BIT] = port_sum_reg; // [RULE12]
    isr_value[GLOBAL_STATUS_BIT] = glob_sum_reg; // [RULE14]
    isr_en_value = DATA_ZERO;
    isr_en_value[PORT_INT_BIT] = port_en_reg;
    isr_en_value[GLOBAL_STATUS_BIT] = glob_en_reg;
    cfg_value = DATA_ZERO;
    cfg_value[CFG_PIN_MODE_LSB+:2] = cfg_reg.pin_mode;
    cfg_value[CFG_IF_MODE_BIT] = cfg_reg.if_mode;
    cfg_value[CFG_REF_IN_BIT] = cfg_reg.ref_in;
    cfg_value[CFG_REF_OUT_BIT] = cfg_reg.ref_out;
    src_value = DATA_ZERO;
    src_value[SRC_A_LSB+:SRC_W] = src_a_reg;
    src_value[SRC_B_LSB+:SRC_W] = src_b_reg;
  end

  // Read data stands only in the cycle after the read strobe.
  always_comb
  begin
    rdata_next = DATA_ZERO;
    if (i_rd)
    begin
      case (i_addr)
        OFS_PIN_CTRL: rdata_next = pin_ctrl_reg;
        OFS_INT_SUMMARY: rdata_next = isr_value; // [RULE17]
        OFS_INT_SUMMARY_EN: rdata_next = isr_en_value;
        OFS_GLOBAL_CFG: rdata_next = cfg_value;
        OFS_PORT_SRC: rdata_next = src_value;
        OFS_EVT_STATUS: rdata_next = {{(DATA_W-NUM_PINS){1'b0}}, evt_status};
        OFS_EVT_ENABLE: rdata_next = {{(DATA_W-NUM_PINS){1'b0}}, evt_enable};
        OFS_PIN_LEVEL: rdata_next = {{(DATA_W-NUM_PINS){1'b0}}, pin_level};
        default: rdata_next = DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      drive_reg <= '0; // [RULE16]
      rdata_reg <= DATA_ZERO;
    end
    else
    begin
      drive_reg <= drive_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_pin_out = drive_reg.out;
  assign o_pin_oe = drive_reg.oe;
  assign o_rdata = rdata_reg;
  assign o_int_n = int_n_reg;

endmodule
`default_nettype wire

// *** include/gpio_summary_pkg.sv ***
package gpio_summary_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int NUM_PINS = 8;
  localparam int SEL_W = 2;
  localparam int SRC_W = 4;
  localparam int STATUS_BITS = 16;
  localparam int ALT_PINS = 4;

  localparam logic [ADDR_W-1:0] OFS_PIN_CTRL = 10'h00a;
  localparam logic [ADDR_W-1:0] OFS_INT_SUMMARY = 10'h010;
  localparam logic [ADDR_W-1:0] OFS_INT_SUMMARY_EN = 10'h012;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_CFG = 10'h020;
  localparam logic [ADDR_W-1:0] OFS_PORT_SRC = 10'h022;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 10'h024;
  localparam logic [ADDR_W-1:0] OFS_EVT_CLEAR = 10'h026;
  localparam logic [ADDR_W-1:0] OFS_EVT_ENABLE = 10'h028;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 10'h02a;

  localparam int PIN1_LSB = 0;
  localparam int PIN2_LSB = 2;
  localparam int PIN3_LSB = 4;
  localparam int PIN4_LSB = 6;
  localparam int PIN5_LSB = 8;
  localparam int PIN6_LSB = 10;
  localparam int PIN7_LSB = 12;
  localparam int PIN8_LSB = 14;

  localparam logic [SEL_W-1:0] SEL_INPUT = 2'h0;
  localparam logic [SEL_W-1:0] SEL_ALT = 2'h1;
  localparam logic [SEL_W-1:0] SEL_LOW = 2'h2;
  localparam logic [SEL_W-1:0] SEL_HIGH = 2'h3;
  localparam logic [1:0] PIN_MODE_OVERRIDE = 2'h1;

  localparam int PORT_INT_BIT = 4;
  localparam int GLOBAL_STATUS_BIT = 0;

  localparam int CFG_PIN_MODE_LSB = 0;
  localparam int CFG_IF_MODE_BIT = 2;
  localparam int CFG_REF_IN_BIT = 3;
  localparam int CFG_REF_OUT_BIT = 4;
  localparam int SRC_A_LSB = 0;
  localparam int SRC_B_LSB = 4;

  localparam logic [DATA_W-1:0] PIN_CTRL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

  typedef struct packed {
    logic [NUM_PINS-1:0] oe;
    logic [NUM_PINS-1:0] out;
  } pin_drive_t;

  typedef struct packed {
    logic [1:0] pin_mode;
    logic if_mode;
    logic ref_in;
    logic ref_out;
  } global_cfg_t;

  function automatic logic [SEL_W-1:0] pin_field(input logic [DATA_W-1:0] ctrl, input int lsb);
    pin_field = ctrl[lsb+:SEL_W];
  endfunction

  // Returns {oe, out} for one pin; code 01 drives the status level only where the pin supports it.
  function automatic logic [1:0] decode_sel(input logic [SEL_W-1:0] sel, input logic alt_ok,
                                            input logic alt_level);
    case (sel)
      SEL_LOW: decode_sel = 2'h2;
      SEL_HIGH: decode_sel = 2'h3;
      SEL_ALT: decode_sel = alt_ok ? {1'b1, alt_level} : 2'h0;
      default: decode_sel = 2'h0;
    endcase
  endfunction

endpackage

// *** testbench/board_pins.sv ***
`timescale 1ns/10ps
`default_nettype none
module board_pins
  (
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_board,
  output logic [7:0] o_level
  );
  // Driven pins show the device level, released pins the board level.
  assign o_level = (i_oe & i_out) | (~i_oe & i_board);
endmodule
`default_nettype wire

// *** testbench/gpio_summary_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module gpio_summary_chk
  import gpio_summary_pkg::*;
  #(parameter int PORT_INTERRUPT_STATUS_REG_W = 16,
    parameter int LATCHED_W = 16)
  (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic [NUM_PINS-1:0] o_pin_out,
  input wire logic [NUM_PINS-1:0] o_pin_oe,
  input wire logic [ALT_PINS-1:0] i_alt_out,
  input wire logic [ALT_PINS-1:0] i_alt_oe,
  input wire logic [STATUS_BITS-1:0] i_port_a_status,
  input wire logic [STATUS_BITS-1:0] i_port_b_status,
  input wire logic [PORT_INTERRUPT_STATUS_REG_W-1:0] i_port_int_status,
  input wire logic [LATCHED_W-1:0] i_latched_status,
  input wire logic [LATCHED_W-1:0] i_latched_enable,
  input wire logic o_int_n
  );
  logic [DATA_W-1:0] pc_reg, pc_next, en_reg, en_next;
  logic [7:0] src_reg, src_next, exp_oe, exp_out;
  logic [4:0] cfg_reg, cfg_next;
  logic wrote_reg, wrote_next, port_any, glob_any, zero_rd;
  logic [1:0] d;
  assign port_any = |i_port_int_status;
  assign glob_any = |(i_latched_status & i_latched_enable);
  assign zero_rd = i_rd && !(i_addr inside {OFS_PIN_CTRL, OFS_INT_SUMMARY, OFS_INT_SUMMARY_EN, OFS_GLOBAL_CFG,
    OFS_PORT_SRC, OFS_EVT_STATUS, OFS_EVT_ENABLE, OFS_PIN_LEVEL});
  always_comb
  begin
    pc_next = (i_wr && i_addr == OFS_PIN_CTRL) ? i_wdata : pc_reg;
    en_next = (i_wr && i_addr == OFS_INT_SUMMARY_EN) ? i_wdata : en_reg;
    cfg_next = (i_wr && i_addr == OFS_GLOBAL_CFG) ? i_wdata[4:0] : cfg_reg;
    src_next = (i_wr && i_addr == OFS_PORT_SRC) ? i_wdata[7:0] : src_reg;
    wrote_next = wrote_reg | (i_wr && (i_addr == OFS_PIN_CTRL || i_addr == OFS_GLOBAL_CFG));
  end
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pc_reg <= '0;
      en_reg <= '0;
      cfg_reg <= '0;
      src_reg <= '0;
      wrote_reg <= 1'b0;
    end
    else
    begin
      pc_reg <= pc_next;
      en_reg <= en_next;
      cfg_reg <= cfg_next;
      src_reg <= src_next;
      wrote_reg <= wrote_next;
    end
  end
  // Expected pin drive from the shadowed registers.
  always_comb
  begin
    d = 2'h0;
    for (int p = 0; p < NUM_PINS; p++)
    begin
      d = pc_reg[2*p+:2];
      exp_oe[p] = d[1];
      exp_out[p] = d[0];
    end
    if (pc_reg[1:0] == SEL_ALT)
      {exp_oe[0], exp_out[0]} = {1'b1, i_port_a_status[src_reg[3:0]]};
    if (pc_reg[3:2] == SEL_ALT)
      {exp_oe[1], exp_out[1]} = {1'b1, i_port_b_status[src_reg[7:4]]};
    if (cfg_reg[4])
      {exp_oe[1], exp_out[1]} = {i_alt_oe[0], i_alt_out[0]};
    if (cfg_reg[3])
      {exp_oe[3], exp_out[3]} = {i_alt_oe[1], i_alt_out[1]};
    if (cfg_reg[2])
      {exp_oe[5], exp_out[5]} = {i_alt_oe[2], i_alt_out[2]};
    if (cfg_reg[1:0] == PIN_MODE_OVERRIDE)
      {exp_oe[7], exp_out[7]} = {i_alt_oe[3], i_alt_out[3]};
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_rd(logic [ADDR_W-1:0] a);
    i_rd && i_addr == a;
  endsequence
  sequence s_steady;
    $stable(port_any) && $stable(glob_any);
  endsequence
  a_pin_enable: assert property (o_pin_oe == $past(exp_oe))
    else $error("pin enable differs from select");
  a_pin_level: assert property ((o_pin_out & $past(exp_oe)) == $past(exp_out & exp_oe))
    else $error("pin level differs from select");
  a_reset_inputs: assert property (!wrote_reg |-> o_pin_oe == 8'h00)
    else $error("pin driven without a select write");
  a_int_port: assert property ((port_any && en_reg[PORT_INT_BIT]) [*3] |-> !o_int_n)
    else $error("port summary did not pull interrupt");
  a_int_global: assert property ((glob_any && en_reg[GLOBAL_STATUS_BIT]) [*3] |-> !o_int_n)
    else $error("global summary did not pull interrupt");
  a_int_release: assert property ((!(port_any && en_reg[4]) && !(glob_any && en_reg[0])) [*3] |-> o_int_n)
    else $error("interrupt held without enabled summary");
  a_read_summary: assert property (s_rd(OFS_INT_SUMMARY) ##0 s_steady
    |=> o_rdata == {11'h000, $past(port_any), 3'h0, $past(glob_any)})
    else $error("summary read wrong");
  a_read_select: assert property (s_rd(OFS_PIN_CTRL) |=> o_rdata == $past(pc_reg))
    else $error("select read wrong");
  a_read_unmapped: assert property (zero_rd |=> o_rdata == DATA_ZERO)
    else $error("unmapped read not zero");
endmodule
bind gpio_summary_top gpio_summary_chk #(.PORT_INTERRUPT_STATUS_REG_W(PORT_INTERRUPT_STATUS_REG_W), .LATCHED_W(LATCHED_W)) u_chk (.*);
`default_nettype wire

// *** testbench/test_global_gpio_and_int_summary.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_global_gpio_and_int_summary;
  import gpio_summary_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, int_n, eirq;
  logic [ADDR_W-1:0] addr = 10'h000;
  logic [DATA_W-1:0] wdata = 16'h0000, rdata, pa = 16'h0000, pb = 16'h0000, pis = 16'h0000;
  logic [DATA_W-1:0] ls = 16'h0000, le = 16'h0000, v;
  logic [7:0] pin_in, pout, poe, lv, board = 8'h00;
  logic [3:0] alt_out = 4'h0, alt_oe = 4'h0;
  logic [DATA_W-1:0] expq[$];
  int n_errors = 0, checked = 0, seed = 69;
  gpio_summary_top u_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_pin_in(pin_in), .o_pin_out(pout), .o_pin_oe(poe), .i_alt_out(alt_out), .i_alt_oe(alt_oe),
    .i_port_a_status(pa), .i_port_b_status(pb), .i_port_int_status(pis), .i_latched_status(ls),
    .i_latched_enable(le), .o_int_n(int_n), .o_event_irq(eirq));
  board_pins u_board (.i_out(pout), .i_oe(poe), .i_board(board), .o_level(pin_in));
  initial
  begin
    forever #2 clk = ~clk;
  end
  task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus cycle; a read notes its expected data.
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= d;
    if (!w)
      expq.push_back(d);
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic test_done;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    rd_d <= rd;
    if (rd_d)
      check("rdata", rdata, expq.pop_front());
  end
  initial
  begin
    #20000;
    n_errors++;
    test_done();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check("oe", {8'h00, poe}, 16'h0000);
    bus(0, OFS_PIN_CTRL, 16'h0000);
    bus(1, OFS_INT_SUMMARY, 16'hffff);
    bus(0, OFS_INT_SUMMARY, 16'h0000);
    bus(0, 10'h3ff, 16'h0000);
    bus(0, OFS_EVT_CLEAR, 16'h0000);
    bus(1, OFS_PORT_SRC, 16'h00c5);
    for (int c = 0; c < 4; c++)
    begin
      board <= 8'($random(seed));
      pa <= 16'($random(seed));
      pb <= 16'($random(seed));
      bus(1, OFS_PIN_CTRL, {8{2'(c)}});
      idle(4);
      lv = (c < 2) ? board : {8{c[0]}};
      if (c == 1)
        lv[1:0] = {pb[12], pa[5]};
      check("oe", {8'h00, poe}, c > 1 ? 16'h00ff : (c == 1 ? 16'h0003 : 16'h0000));
      bus(0, OFS_PIN_LEVEL, {8'h00, lv});
      bus(0, OFS_PIN_CTRL, {8{2'(c)}});
    end
    alt_oe <= 4'hf;
    alt_out <= 4'h0;
    bus(1, OFS_PIN_CTRL, 16'hffff);
    for (int j = 0; j < 5; j++)
    begin
      bus(1, OFS_GLOBAL_CFG, 16'h0001 << j);
      idle(4);
      lv = 8'hff;
      if (j != 1)
        lv[j == 0 ? 7 : 9 - 2 * j] = 1'b0;
      bus(0, OFS_PIN_LEVEL, {8'h00, lv});
    end
    bus(1, OFS_GLOBAL_CFG, 16'h0000);
    bus(1, OFS_INT_SUMMARY_EN, 16'h0011);
    pis <= 16'h8000;
    idle(3);
    check("int", {15'h0000, int_n}, 16'h0000);
    bus(0, OFS_INT_SUMMARY, 16'h0010);
    pis <= 16'h0000;
    ls <= 16'h0100;
    idle(3);
    check("int", {15'h0000, int_n}, 16'h0001);
    bus(0, OFS_INT_SUMMARY, 16'h0000);
    le <= 16'h0100;
    idle(3);
    check("int", {15'h0000, int_n}, 16'h0000);
    bus(0, OFS_INT_SUMMARY, 16'h0001);
    bus(1, OFS_INT_SUMMARY_EN, 16'h0010);
    idle(3);
    check("int", {15'h0000, int_n}, 16'h0001);
    bus(1, OFS_EVT_CLEAR, 16'h00ff);
    bus(1, OFS_EVT_ENABLE, 16'h00ff);
    v = 16'haaaa | (16'($random(seed)) & 16'h5554);
    for (int p = 0; p < 8; p++)
      lv[p] = ~v[2*p];
    bus(1, OFS_PIN_CTRL, v);
    idle(6);
    bus(0, OFS_EVT_STATUS, {8'h00, lv});
    check("irq", {15'h0000, eirq}, 16'h0001);
    bus(1, OFS_EVT_ENABLE, 16'h0000);
    idle(1);
    check("irq", {15'h0000, eirq}, 16'h0000);
    bus(1, OFS_EVT_CLEAR, 16'h00ff);
    bus(0, OFS_EVT_STATUS, 16'h0000);
    idle(2);
    rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    idle(1);
    check("oe", {8'h00, poe}, 16'h0000);
    bus(0, OFS_PIN_CTRL, 16'h0000);
    idle(3);
    bus(0, OFS_EVT_STATUS, 16'h0000);
    idle(2);
    test_done();
  end
endmodule
`default_nettype wire
